// ===== shared/wol_regs.svh
// Register offsets, field positions, reset values and timing counts of the option latches.
`ifndef WOL_REGS_SVH
`define WOL_REGS_SVH
// Printed register indices; the byte address is four times the index.
`define WOL_IDX_OPT_TWO 8'h1E
`define WOL_IDX_OPT_ONE 8'h1F
`define WOL_ADDR_W 8
// Field positions in the second option latch.
`define WOL_B2_OSC_STOP 0
`define WOL_B2_XTAL 1
`define WOL_B2_SLOW 2
`define WOL_B2_EXT_CLK 3
// Field positions in the first option latch.
`define WOL_B1_WDOG_DIS 0
`define WOL_B1_STOP_EN 1
`define WOL_B1_SHORT_REC 2
`define WOL_B1_VMODE 3
`define WOL_B1_VM_PWRD 4
`define WOL_B1_VM_RSTD 5
`define WOL_B1_VM_STOP 6
`define WOL_B1_WDOG_RATE 7
// Reset values and the writable bits of the second latch.
`define WOL_RST_OPT 8'h00
`define WOL_MASK_TWO 8'h0F
// Counts handed to the clock monitor, watchdog and stop recovery.
`define WOL_STAB_XTAL 13'h1000
`define WOL_STAB_EXT 13'h0010
`define WOL_WDOG_LONG 18'h3_FFF0
`define WOL_WDOG_SHORT 18'h0_1FF0
`define WOL_REC_LONG 13'h1000
`define WOL_REC_SHORT 13'h0020
`endif

// ===== shared/wol_pkg.sv
// Types shared by the option latch bank.
package wol_pkg;
	// Clock-related options, second latch.
	typedef struct packed {
		logic [3:0] spare;
		logic external_clock_enable;
		logic slow_crystal_select;
		logic crystal_enable;
		logic oscillator_in_stop_enable;
	} wol_opt_two_s;
	// System options, first latch.
	typedef struct packed {
		logic watchdog_rate_select;
		logic voltage_monitor_stop_enable;
		logic voltage_monitor_reset_disable;
		logic voltage_monitor_power_down;
		logic voltage_mode_select;
		logic short_stop_recovery;
		logic stop_enable;
		logic watchdog_disable;
	} wol_opt_one_s;
	// Frequency band the clock monitor is told to expect.
	typedef enum logic [2:0] {
		MON_OFF,
		MON_XTAL_FAST,
		MON_XTAL_SLOW,
		MON_EXT_HIGH,
		MON_EXT_LOW
	} wol_range_e;
endpackage : wol_pkg

// ===== rtl/wol_option_latches.sv
// Write-once option latch bank with APB access and option control outputs.
//
// The register offsets and the APB register port were chosen for this implementation.
`include "wol_regs.svh"
module wol_option_latches
	import wol_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic POR_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [`WOL_ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic STOP_EXEC,
	input wire logic STOP_MODE,
	input wire logic STOP_EXIT_VM,
	input wire logic VM_RESET_REQ,
	output logic XTAL_IN_CLOCK,
	output logic XTAL_OUT_CRYSTAL,
	output logic [2:0] MON_RANGE,
	output logic [12:0] STAB_COUNT,
	output logic GEN_RUN_IN_STOP,
	output logic GEN_CLK_HOLD_LOW,
	output logic [17:0] WDOG_TIMEOUT,
	output logic WDOG_DISABLE,
	output logic VM_POWER_ON,
	output logic VM_RESET_OUT,
	output logic VM_FIVE_VOLT,
	output logic [12:0] RECOVERY_COUNT,
	output logic STOP_ACCEPT,
	output logic ILLEGAL_OPCODE
);

	// Any reset source; the power-on reset also counts as an ordinary one.
	logic any_rst;
	assign any_rst = !RST_N || !POR_N;

	// Byte addresses of the two latches.
	localparam logic [`WOL_ADDR_W-1:0] ADDR_TWO = `WOL_ADDR_W'(`WOL_IDX_OPT_TWO * 4);
	localparam logic [`WOL_ADDR_W-1:0] ADDR_ONE = `WOL_ADDR_W'(`WOL_IDX_OPT_ONE * 4);

	wol_opt_two_s opt_two_reg; // Second option latch.
	wol_opt_one_s opt_one_reg; // First option latch.
	logic lock_two_reg; // Second latch has taken its write.
	logic lock_one_reg; // First latch has taken its write.
	logic lock_vmode_reg; // Voltage mode bit has taken its write.
	logic pready_reg; // Ready for the access phase.

	// Decode of the bus request.
	logic setup_cyc;
	logic access_wr;
	logic hit_two;
	logic hit_one;
	assign setup_cyc = PSEL && !PENABLE;
	assign access_wr = PSEL && PENABLE && pready_reg && PWRITE;
	assign hit_two = (PADDR == ADDR_TWO);
	assign hit_one = (PADDR == ADDR_ONE);

	// Ready rises for exactly the access phase, so every transfer has no wait state.
	always_ff @(posedge CLK)
	begin
		if (any_rst)
		begin
			pready_reg <= 1'b0;
		end
		else
		begin
			pready_reg <= setup_cyc;
		end
	end
	assign PREADY = pready_reg;

	// Read data and error are captured at setup so they stand through the access phase.
	always_ff @(posedge CLK)
	begin
		if (any_rst)
		begin
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
		else if (setup_cyc)
		begin
			// Both latches read back at any time, locked or not.
			if (hit_two)
			begin
				PRDATA <= {24'h00_0000, opt_two_reg};
			end
			else if (hit_one)
			begin
				PRDATA <= {24'h00_0000, opt_one_reg};
			end
			else
			begin
				PRDATA <= 32'h0000_0000;
			end
			// An unmapped address is answered with an error and changes nothing.
			PSLVERR <= !(hit_two || hit_one);
		end
	end

	// Second latch: one write after each reset, later writes dropped.
	always_ff @(posedge CLK)
	begin
		if (any_rst)
		begin
			opt_two_reg <= `WOL_RST_OPT;
			lock_two_reg <= 1'b0;
		end
		else if (access_wr && hit_two && !lock_two_reg)
		begin
			opt_two_reg <= PWDATA[7:0] & `WOL_MASK_TWO;
			lock_two_reg <= 1'b1;
		end
	end

	// First latch except the voltage mode bit.
	always_ff @(posedge CLK)
	begin
		if (any_rst)
		begin
			// Every bit but voltage mode returns to zero.
			opt_one_reg.watchdog_rate_select <= 1'b0;
			opt_one_reg.voltage_monitor_stop_enable <= 1'b0;
			opt_one_reg.voltage_monitor_reset_disable <= 1'b0;
			opt_one_reg.voltage_monitor_power_down <= 1'b0;
			opt_one_reg.short_stop_recovery <= 1'b0;
			opt_one_reg.stop_enable <= 1'b0;
			opt_one_reg.watchdog_disable <= 1'b0;
			lock_one_reg <= 1'b0;
		end
		else if (access_wr && hit_one && !lock_one_reg)
		begin
			opt_one_reg.watchdog_rate_select <= PWDATA[`WOL_B1_WDOG_RATE];
			opt_one_reg.voltage_monitor_stop_enable <= PWDATA[`WOL_B1_VM_STOP];
			opt_one_reg.voltage_monitor_reset_disable <= PWDATA[`WOL_B1_VM_RSTD];
			opt_one_reg.voltage_monitor_power_down <= PWDATA[`WOL_B1_VM_PWRD];
			opt_one_reg.short_stop_recovery <= PWDATA[`WOL_B1_SHORT_REC];
			opt_one_reg.stop_enable <= PWDATA[`WOL_B1_STOP_EN];
			opt_one_reg.watchdog_disable <= PWDATA[`WOL_B1_WDOG_DIS];
			lock_one_reg <= 1'b1;
		end
	end

	// Voltage mode bit: only power-on clears it or its lock, so a warm reset
	// cannot be used to retarget the trip point.
	always_ff @(posedge CLK)
	begin
		if (!POR_N)
		begin
			opt_one_reg.voltage_mode_select <= 1'b0;
			lock_vmode_reg <= 1'b0;
		end
		else if (RST_N && access_wr && hit_one && !lock_vmode_reg)
		begin
			opt_one_reg.voltage_mode_select <= PWDATA[`WOL_B1_VMODE];
			lock_vmode_reg <= 1'b1;
		end
	end

	// Clock pin and monitor setup derived from the latched options.
	logic ext_on;
	logic slow_eff;
	wol_range_e range_next;
	assign ext_on = opt_two_reg.external_clock_enable;
	assign slow_eff = ext_on && opt_two_reg.slow_crystal_select;

	// Monitor band selection.
	always_comb
	begin
		range_next = MON_OFF;
		case ({ext_on, opt_two_reg.crystal_enable})
			2'b11: range_next = slow_eff ? MON_XTAL_SLOW : MON_XTAL_FAST;
			2'b10: range_next = slow_eff ? MON_EXT_LOW : MON_EXT_HIGH;
			default: range_next = MON_OFF;
		endcase
	end

	// Clock generator and pin controls, registered so outputs come from flops.
	always_ff @(posedge CLK)
	begin
		if (any_rst)
		begin
			XTAL_IN_CLOCK <= 1'b0;
			XTAL_OUT_CRYSTAL <= 1'b0;
			MON_RANGE <= MON_OFF;
			STAB_COUNT <= `WOL_STAB_EXT;
			GEN_RUN_IN_STOP <= 1'b0;
			GEN_CLK_HOLD_LOW <= 1'b0;
		end
		else
		begin
			XTAL_IN_CLOCK <= ext_on;
			XTAL_OUT_CRYSTAL <= ext_on && opt_two_reg.crystal_enable;
			MON_RANGE <= range_next;
			// Crystals need a long start-up; a driven clock does not.
			STAB_COUNT <= opt_two_reg.crystal_enable ? `WOL_STAB_XTAL : `WOL_STAB_EXT;
			GEN_RUN_IN_STOP <= opt_two_reg.oscillator_in_stop_enable;
			GEN_CLK_HOLD_LOW <= STOP_MODE && !opt_two_reg.oscillator_in_stop_enable;
		end
	end

	// Watchdog and voltage monitor controls.
	always_ff @(posedge CLK)
	begin
		if (any_rst)
		begin
			WDOG_TIMEOUT <= `WOL_WDOG_SHORT;
			WDOG_DISABLE <= 1'b0;
			VM_POWER_ON <= 1'b1;
			VM_RESET_OUT <= 1'b0;
			VM_FIVE_VOLT <= 1'b0;
		end
		else
		begin
			WDOG_TIMEOUT <= opt_one_reg.watchdog_rate_select ? `WOL_WDOG_LONG
				: `WOL_WDOG_SHORT;
			WDOG_DISABLE <= opt_one_reg.watchdog_disable;
			// Powered unless disabled; in stop only with the stop option.
			VM_POWER_ON <= !opt_one_reg.voltage_monitor_power_down
				&& (!STOP_MODE || opt_one_reg.voltage_monitor_stop_enable);
			VM_RESET_OUT <= VM_RESET_REQ && !opt_one_reg.voltage_monitor_reset_disable
				&& !opt_one_reg.voltage_monitor_power_down;
			VM_FIVE_VOLT <= opt_one_reg.voltage_mode_select;
		end
	end

	// Stop recovery and stop instruction handling. The block trusts software not to pick
	// short recovery when the oscillator stops in stop mode; it does not check it.
	always_ff @(posedge CLK)
	begin
		if (any_rst)
		begin
			RECOVERY_COUNT <= `WOL_REC_LONG;
			STOP_ACCEPT <= 1'b0;
			ILLEGAL_OPCODE <= 1'b0;
		end
		else
		begin
			// A monitor reset exit always takes the long delay.
			RECOVERY_COUNT <= (opt_one_reg.short_stop_recovery && !STOP_EXIT_VM)
				? `WOL_REC_SHORT : `WOL_REC_LONG;
			STOP_ACCEPT <= STOP_EXEC && opt_one_reg.stop_enable;
			ILLEGAL_OPCODE <= STOP_EXEC && !opt_one_reg.stop_enable;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (any_rst);

	// A locked latch keeps its value across a write.
	lock_hold_a: assert property (access_wr && hit_two && lock_two_reg |=> $stable(opt_two_reg))
		else $error("locked second latch changed on write");
	lock_one_a: assert property (access_wr && hit_one && lock_one_reg |=> $stable(opt_one_reg))
		else $error("locked first latch changed on write");
	// The first write lands in the latch.
	first_write_a: assert property (access_wr && hit_two && !lock_two_reg
		|=> opt_two_reg == ($past(PWDATA[7:0]) & `WOL_MASK_TWO) && lock_two_reg)
		else $error("first write not stored");
	// An ordinary reset clears the second latch and stop enable and keeps voltage mode; power-on clears voltage mode.
	reset_clear_a: assert property (disable iff (1'b0) POR_N && !RST_N
		|=> opt_two_reg == `WOL_RST_OPT && opt_one_reg.stop_enable == 1'b0
		&& $stable(opt_one_reg.voltage_mode_select))
		else $error("ordinary reset wrong");
	vmode_por_a: assert property (disable iff (1'b0) !POR_N |=> !opt_one_reg.voltage_mode_select)
		else $error("power-on reset left voltage mode set");
	// Read data matches the latch through the access phase.
	read_back_a: assert property (setup_cyc && hit_one && !PWRITE
		|=> PREADY && PRDATA == {24'h00_0000, $past(opt_one_reg)})
		else $error("read back mismatch");
	pins_a: assert property (##1 XTAL_OUT_CRYSTAL
		== $past(opt_two_reg.external_clock_enable && opt_two_reg.crystal_enable))
		else $error("crystal pin control wrong");
	stab_a: assert property (opt_two_reg.crystal_enable ##1 1'b1
		|-> STAB_COUNT == `WOL_STAB_XTAL || $past(any_rst))
		else $error("stabilization count wrong");
	recov_a: assert property (STOP_EXIT_VM |=> RECOVERY_COUNT == `WOL_REC_LONG)
		else $error("monitor exit used short recovery");
	stop_ill_a: assert property (STOP_EXEC && !opt_one_reg.stop_enable
		|=> ILLEGAL_OPCODE && !STOP_ACCEPT)
		else $error("disabled stop not illegal");
	vm_block_a: assert property (opt_one_reg.voltage_monitor_reset_disable
		|=> !VM_RESET_OUT)
		else $error("monitor reset not blocked");

endmodule : wol_option_latches

// ===== tb/tb_wol_option_latches.sv
// Self-checking random bench for the write-once option latch bank.
`include "wol_regs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
module tb_wol_option_latches
	import wol_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Every design input has a value from time zero; both resets start asserted.
	logic CLK = 1'b0, RST_N = 1'b0, POR_N = 1'b0;
	logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0000_0000;
	logic STOP_EXEC = 1'b0, STOP_MODE = 1'b0, STOP_EXIT_VM = 1'b0, VM_RESET_REQ = 1'b0;
	logic [31:0] PRDATA;
	logic PREADY, PSLVERR, XTAL_IN_CLOCK, XTAL_OUT_CRYSTAL, GEN_RUN_IN_STOP;
	logic GEN_CLK_HOLD_LOW, WDOG_DISABLE, VM_POWER_ON, VM_RESET_OUT, VM_FIVE_VOLT;
	logic STOP_ACCEPT, ILLEGAL_OPCODE;
	logic [2:0] MON_RANGE;
	logic [12:0] STAB_COUNT, RECOVERY_COUNT;
	logic [17:0] WDOG_TIMEOUT;
	// Bench copy of both latches and of the three locks.
	logic [7:0] e_two = 8'h00, e_one = 8'h00;
	bit lk1, lk2, lkv;
	int n_errors = 0, checks_done = 0;
	integer seed = 32'h21b0;
	wol_option_latches i_dut (.CLK(CLK), .RST_N(RST_N), .POR_N(POR_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .STOP_EXEC(STOP_EXEC), .STOP_MODE(STOP_MODE),
		.STOP_EXIT_VM(STOP_EXIT_VM), .VM_RESET_REQ(VM_RESET_REQ),
		.XTAL_IN_CLOCK(XTAL_IN_CLOCK), .XTAL_OUT_CRYSTAL(XTAL_OUT_CRYSTAL),
		.MON_RANGE(MON_RANGE), .STAB_COUNT(STAB_COUNT), .GEN_RUN_IN_STOP(GEN_RUN_IN_STOP),
		.GEN_CLK_HOLD_LOW(GEN_CLK_HOLD_LOW), .WDOG_TIMEOUT(WDOG_TIMEOUT),
		.WDOG_DISABLE(WDOG_DISABLE), .VM_POWER_ON(VM_POWER_ON), .VM_RESET_OUT(VM_RESET_OUT),
		.VM_FIVE_VOLT(VM_FIVE_VOLT), .RECOVERY_COUNT(RECOVERY_COUNT),
		.STOP_ACCEPT(STOP_ACCEPT), .ILLEGAL_OPCODE(ILLEGAL_OPCODE));
	// A 25 ns period gives the 40 MHz system clock.
	always #12.5 CLK = ~CLK;
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	// One APB transfer; the request is held until PREADY is seen high at an edge.
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= ad;
		PWDATA <= wd;
		@(posedge CLK);
		PENABLE <= 1'b1;
		// Outputs are looked at mid-cycle, where they have settled; reading them right
		// after the rising edge would race the flops that launch them.
		@(negedge CLK);
		while (PREADY !== 1'b1 && n < 20)
		begin
			@(negedge CLK);
			n++;
		end
		`CHK("pready", 1'b1, PREADY)
		// The registered answer stands through the edge at which the access completes.
		rd = PRDATA;
		er = PSLVERR;
		@(posedge CLK);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		// Let one idle edge pass so that the next call never drives PSEL twice in a step.
		@(posedge CLK);
	endtask : apb
	// Writes one latch and updates the bench copy as the lock rules allow.
	task automatic wr(input bit one, input logic [7:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, one ? 8'(`WOL_IDX_OPT_ONE * 4) : 8'(`WOL_IDX_OPT_TWO * 4), {24'h0, d}, rd, er);
		`CHK("wr_err", 1'b0, er)
		if (!one && !lk2)
			e_two = d & `WOL_MASK_TWO;
		if (one && !lk1)
			e_one = {d[7:4], e_one[3], d[2:0]};
		if (one && !lkv)
			e_one[`WOL_B1_VMODE] = d[`WOL_B1_VMODE];
		lk2 = lk2 | !one;
		lk1 = lk1 | one;
		lkv = lkv | one;
	endtask : wr
	// Reads both latches back; they stay readable after locking.
	task automatic rd_chk();
		logic [31:0] rd;
		logic er;
		apb(1'b0, 8'(`WOL_IDX_OPT_TWO * 4), 32'h0000_0000, rd, er);
		`CHK("rd_two", {24'h0, e_two}, rd)
		apb(1'b0, 8'(`WOL_IDX_OPT_ONE * 4), 32'h0000_0000, rd, er);
		`CHK("rd_one", {24'h0, e_one}, rd)
		`CHK("rd_err", 1'b0, er)
	endtask : rd_chk
	// Holds reset two cycles; a power-on reset also clears the voltage mode bit.
	task automatic do_reset(input bit por);
		RST_N <= 1'b0;
		POR_N <= !por;
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		POR_N <= 1'b1;
		e_two = `WOL_RST_OPT;
		e_one = por ? `WOL_RST_OPT : (e_one & 8'h08);
		lk1 = 1'b0;
		lk2 = 1'b0;
		lkv = lkv & !por;
	endtask : do_reset
	// Works out every control output from the bench copy and the side inputs.
	task automatic check_outs();
		wol_opt_two_s t;
		wol_opt_one_s o;
		wol_range_e r;
		t = e_two;
		o = e_one;
		r = !t.external_clock_enable ? MON_OFF : t.crystal_enable ?
			(t.slow_crystal_select ? MON_XTAL_SLOW : MON_XTAL_FAST) :
			(t.slow_crystal_select ? MON_EXT_LOW : MON_EXT_HIGH);
		`CHK("xin", t.external_clock_enable, XTAL_IN_CLOCK)
		`CHK("xout", t.external_clock_enable & t.crystal_enable, XTAL_OUT_CRYSTAL)
		`CHK("mon", 3'(r), MON_RANGE)
		`CHK("stab", t.crystal_enable ? `WOL_STAB_XTAL : `WOL_STAB_EXT, STAB_COUNT)
		`CHK("run", t.oscillator_in_stop_enable, GEN_RUN_IN_STOP)
		`CHK("hold", STOP_MODE & !t.oscillator_in_stop_enable, GEN_CLK_HOLD_LOW)
		`CHK("wdt", o.watchdog_rate_select ? `WOL_WDOG_LONG : `WOL_WDOG_SHORT, WDOG_TIMEOUT)
		`CHK("wdd", o.watchdog_disable, WDOG_DISABLE)
		`CHK("vpwr", !o.voltage_monitor_power_down &
			(!STOP_MODE | o.voltage_monitor_stop_enable), VM_POWER_ON)
		`CHK("vrst", VM_RESET_REQ & !o.voltage_monitor_reset_disable &
			!o.voltage_monitor_power_down, VM_RESET_OUT)
		`CHK("v5", o.voltage_mode_select, VM_FIVE_VOLT)
		`CHK("rec", (o.short_stop_recovery & !STOP_EXIT_VM) ?
			`WOL_REC_SHORT : `WOL_REC_LONG, RECOVERY_COUNT)
		`CHK("stop", STOP_EXEC & o.stop_enable, STOP_ACCEPT)
		`CHK("ill", STOP_EXEC & !o.stop_enable, ILLEGAL_OPCODE)
	endtask : check_outs
	// Corner cases first, then random writes, stray accesses and resets.
	initial
	begin
		logic [31:0] rd;
		logic er;
		int k;
		logic [7:0] d;
		do_reset(1'b1);
		rd_chk();
		wr(1'b1, 8'hFF);
		do_reset(1'b0);
		wr(1'b1, 8'h00);
		wr(1'b1, 8'hF7);
		rd_chk();
		do_reset(1'b1);
		for (int i = 0; i < 300; i++)
		begin
			k = {$random(seed)} % 10;
			case (k)
				0, 1, 2: wr(1'b0, 8'($random(seed)));
				3, 4, 5:
				begin
					d = 8'($random(seed));
					// Short recovery only with the oscillator kept in stop or a driven clock.
					if (!e_two[`WOL_B2_OSC_STOP] && !(e_two[`WOL_B2_EXT_CLK] && !e_two[`WOL_B2_XTAL]))
						d[`WOL_B1_SHORT_REC] = 1'b0;
					wr(1'b1, d);
				end
				6:
				begin
					// Both latch addresses have a nonzero low nibble, so this never hits one.
					apb(1'($random(seed)), 8'($random(seed)) & 8'hF0, 32'($random(seed)), rd, er);
					`CHK("bad_err", 1'b1, er)
				end
				7: do_reset(1'b0);
				8: if (i % 3 == 0) do_reset(1'b1);
				default: rd_chk();
			endcase
			{STOP_EXEC, STOP_MODE, STOP_EXIT_VM, VM_RESET_REQ} <= 4'($random(seed));
			repeat (2) @(posedge CLK);
			check_outs();
		end
		rd_chk();
		summarize();
	end
	// A hang is cut short well past the 1500 or so cycles the run needs.
	initial
	begin
		repeat (20000) @(posedge CLK);
		n_errors++;
		summarize();
	end
endmodule : tb_wol_option_latches
